// File: aps_map.svh
`ifndef APS_MAP_SVH
`define APS_MAP_SVH
// Register offsets on the control port.
`define APS_ADDR_REF_CTRL 8'h27
`define APS_ADDR_FRAC_HIGH 8'h28
`define APS_ADDR_FRAC_LOW 8'h29
`define APS_ADDR_WHOLE 8'h2a
`define APS_ADDR_STATUS 8'h2b
`define APS_ADDR_RATE 8'h17
// Field positions.
`define APS_MODE_HI 7
`define APS_MODE_LO 6
`define APS_INDIV_HI 4
`define APS_INDIV_LO 2
`define APS_WHOLE_W 7
`define APS_FRAC_HIGH_W 5
// Reset values.
`define APS_REF_CTRL_RST 8'h00
`define APS_FRAC_HIGH_RST 8'h00
`define APS_FRAC_LOW_RST 8'h00
`define APS_WHOLE_RST 8'h20
`define APS_RATE_RST 8'h0b
// Clock source selection codes.
`define APS_MODE_BYPASS 2'h0
`define APS_MODE_NORMAL 2'h1
`define APS_MODE_SRM 2'h2
// Timing: master clock is lost after 1000 ns without an edge (about 500 kHz, as both edges count).
`define APS_CLK_PERIOD_NS 10
`define APS_DETECT_WINDOW_NS 1000
`define APS_DETECT_CYCLES (`APS_DETECT_WINDOW_NS / `APS_CLK_PERIOD_NS)
// Oscillator runs at eight times the system clock.
`define APS_POSTDIV 4'h8
`endif

// File: aps_mclk_model.sv
`timescale 1ns/1ps
`default_nettype none
module aps_mclk_model #(
    parameter int HALF_NS = 40,
    parameter int LOCK_CYC = 20
) (
    // Logic clock
    input wire logic mclk,
    // Control
    input wire logic run,
    input wire logic pll_enable,
    input wire logic restart,
    // Pins
    output logic pin,
    output logic lock
);
    int cnt_q;
    // A stopped source leaves the pin at its last level, so loss shows only through the detector timeout.
    initial begin
        pin = 1'b0;
        forever begin
            #(HALF_NS);
            if (run) begin
                pin = ~pin;
            end
        end
    end
    // Lock drops on every restart, so the block must fall back until it relocks.
    always_ff @(posedge mclk) begin
        if (!pll_enable || restart) begin
            cnt_q <= 0;
        end else if (cnt_q < LOCK_CYC) begin
            cnt_q <= cnt_q + 1;
        end
    end
    assign lock = (cnt_q == LOCK_CYC);
endmodule
`default_nettype wire

// File: aps_pkg.sv
`default_nettype none
package aps_pkg;
    typedef enum logic [1:0] {
        APS_SRC_REFOSC,
        APS_SRC_MCLK,
        APS_SRC_PLL
    } aps_src_type;

    typedef struct packed {
        logic pll_enable;
        logic srm_enable;
        logic [4:0] predivide;
        logic [19:0] feedback_div;
        logic [3:0] postdivide;
    } aps_pll_ctrl_type;

    typedef struct packed {
        aps_src_type source;
        logic family_44k1;
        logic refosc_enable;
        logic digital_ok;
    } aps_sysclk_type;
endpackage
`default_nettype wire

// File: aps_sysclk_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "aps_map.svh"

module aps_sysclk_select (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Pins and analog status
    input wire logic ext_mclk_pin,
    input wire logic pll_lock_pin,
    // Clock control outputs
    output aps_pkg::aps_pll_ctrl_type pll_ctrl,
    output logic pll_restart,
    output aps_pkg::aps_sysclk_type sysclk
);
    localparam int DET_W = 8;
    localparam logic [DET_W-1:0] DET_LAST = DET_W'(`APS_DETECT_CYCLES - 1);

    function automatic logic family_is_44k1(input logic [3:0] code);
        family_is_44k1 = (code[1:0] == 2'h2);
    endfunction

    function automatic logic [4:0] predivide_ratio(input logic [2:0] code);
        case (code)
            3'h0: predivide_ratio = 5'h01;
            3'h1: predivide_ratio = 5'h02;
            3'h2: predivide_ratio = 5'h04;
            3'h3: predivide_ratio = 5'h08;
            default: predivide_ratio = 5'h10;
        endcase
    endfunction

    // Register file.
    logic [7:0] ref_ctrl_q, ref_ctrl_d;
    logic [7:0] frac_high_q, frac_high_d;
    logic [7:0] frac_low_q, frac_low_d;
    logic [7:0] whole_q, whole_d;
    logic [7:0] rate_q, rate_d;
    logic [7:0] rdata_q, rdata_d;
    logic restart_q, restart_d;
    // Synchronisers and detector.
    logic [2:0] mclk_sync_q, mclk_sync_d;
    logic [1:0] lock_sync_q, lock_sync_d;
    logic [DET_W-1:0] det_cnt_q, det_cnt_d;
    logic det_q, det_d;
    // Source selection and outputs.
    aps_pkg::aps_src_type src_q, src_d;
    // Set by a loop restart and held until the synchronised lock has been seen low,
    // because the lock flag lags the restart by the synchroniser depth.
    logic relock_q, relock_d;
    aps_pkg::aps_pll_ctrl_type ctrl_q, ctrl_d;
    aps_pkg::aps_sysclk_type sys_q, sys_d;

    logic [1:0] mode;
    logic locked;
    logic [7:0] status;

    assign mode = ref_ctrl_q[`APS_MODE_HI:`APS_MODE_LO];
    assign locked = lock_sync_q[1];
    assign status = {4'h0, src_q, locked, det_q};

    // Register writes and reads.
    always_comb begin
        ref_ctrl_d = ref_ctrl_q;
        frac_high_d = frac_high_q;
        frac_low_d = frac_low_q;
        whole_d = whole_q;
        rate_d = rate_q;
        restart_d = 1'b0;
        rdata_d = rdata_q;
        if (reg_wr) begin
            case (reg_addr)
                `APS_ADDR_REF_CTRL: ref_ctrl_d = reg_wdata;
                `APS_ADDR_FRAC_HIGH: frac_high_d = {3'h0, reg_wdata[`APS_FRAC_HIGH_W-1:0]};
                `APS_ADDR_FRAC_LOW: frac_low_d = reg_wdata;
                `APS_ADDR_WHOLE: begin
                    // Rewriting the whole part restarts the loop, which is the
                    // recovery path after the word clock was removed in matching mode.
                    whole_d = {1'b0, reg_wdata[`APS_WHOLE_W-1:0]};
                    restart_d = 1'b1;
                end
                `APS_ADDR_RATE: rate_d = {4'h0, reg_wdata[3:0]};
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `APS_ADDR_REF_CTRL: rdata_d = ref_ctrl_q;
                `APS_ADDR_FRAC_HIGH: rdata_d = frac_high_q;
                `APS_ADDR_FRAC_LOW: rdata_d = frac_low_q;
                `APS_ADDR_WHOLE: rdata_d = whole_q;
                `APS_ADDR_RATE: rdata_d = rate_q;
                `APS_ADDR_STATUS: rdata_d = status;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ref_ctrl_q <= `APS_REF_CTRL_RST;
            frac_high_q <= `APS_FRAC_HIGH_RST;
            frac_low_q <= `APS_FRAC_LOW_RST;
            whole_q <= `APS_WHOLE_RST;
            rate_q <= `APS_RATE_RST;
            rdata_q <= 8'h00;
            restart_q <= 1'b0;
        end else begin
            ref_ctrl_q <= ref_ctrl_d;
            frac_high_q <= frac_high_d;
            frac_low_q <= frac_low_d;
            whole_q <= whole_d;
            rate_q <= rate_d;
            rdata_q <= rdata_d;
            restart_q <= restart_d;
        end
    end

    // Master clock detector. The pin is sampled on the logic clock, so a fast
    // master clock aliases; any toggle seen inside the window counts as alive,
    // which only has to tell a running clock from a stopped or very slow one.
    always_comb begin
        mclk_sync_d = {mclk_sync_q[1:0], ext_mclk_pin};
        lock_sync_d = {lock_sync_q[0], pll_lock_pin};
        det_cnt_d = det_cnt_q;
        det_d = det_q;
        if (mclk_sync_q[2] != mclk_sync_q[1]) begin
            det_cnt_d = '0;
            det_d = 1'b1;
        end else if (det_cnt_q == DET_LAST) begin
            det_d = 1'b0;
        end else begin
            det_cnt_d = det_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mclk_sync_q <= 3'h0;
            lock_sync_q <= 2'h0;
            det_cnt_q <= '0;
            det_q <= 1'b0;
        end else begin
            mclk_sync_q <= mclk_sync_d;
            lock_sync_q <= lock_sync_d;
            det_cnt_q <= det_cnt_d;
            det_q <= det_d;
        end
    end

    // Source selection and PLL control.
    always_comb begin
        src_d = src_q;
        relock_d = relock_q;
        if (restart_q) begin
            relock_d = 1'b1;
        end else if (!locked) begin
            relock_d = 1'b0;
        end
        ctrl_d.pll_enable = 1'b0;
        ctrl_d.srm_enable = 1'b0;
        ctrl_d.predivide = predivide_ratio(ref_ctrl_q[`APS_INDIV_HI:`APS_INDIV_LO]);
        ctrl_d.feedback_div = {whole_q[`APS_WHOLE_W-1:0], frac_high_q[`APS_FRAC_HIGH_W-1:0],
            frac_low_q};
        ctrl_d.postdivide = `APS_POSTDIV;
        case (mode)
            `APS_MODE_NORMAL, `APS_MODE_SRM: begin
                ctrl_d.pll_enable = det_q;
                ctrl_d.srm_enable = det_q && (mode == `APS_MODE_SRM);
                if (!det_q) begin
                    src_d = aps_pkg::APS_SRC_REFOSC;
                end else if (locked && !restart_q && !relock_q) begin
                    src_d = aps_pkg::APS_SRC_PLL;
                end else if (src_q == aps_pkg::APS_SRC_PLL) begin
                    // Lock lost or loop restarted: fall back to the master clock rather than
                    // run from an unlocked loop.
                    src_d = aps_pkg::APS_SRC_MCLK;
                end else begin
                    src_d = src_q;
                end
            end
            default: begin
                src_d = det_q ? aps_pkg::APS_SRC_MCLK : aps_pkg::APS_SRC_REFOSC;
            end
        endcase
        sys_d.source = src_d;
        sys_d.family_44k1 = family_is_44k1(rate_q[3:0]);
        sys_d.refosc_enable = (src_d == aps_pkg::APS_SRC_REFOSC);
        sys_d.digital_ok = (src_d != aps_pkg::APS_SRC_REFOSC);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            src_q <= aps_pkg::APS_SRC_REFOSC;
            relock_q <= 1'b0;
            ctrl_q <= '0;
            sys_q <= '0;
        end else begin
            src_q <= src_d;
            relock_q <= relock_d;
            ctrl_q <= ctrl_d;
            sys_q <= sys_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign pll_restart = restart_q;
    assign pll_ctrl = ctrl_q;
    assign sysclk = sys_q;
endmodule
`default_nettype wire

// File: aps_sysclk_select_properties.sv
`timescale 1ns/1ps
`default_nettype none
module aps_sysclk_select_properties (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins and clock control
    input wire logic ext_mclk_pin,
    input wire logic pll_lock_pin,
    input wire aps_pkg::aps_pll_ctrl_type pll_ctrl,
    input wire logic pll_restart,
    input wire aps_pkg::aps_sysclk_type sysclk
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire logic wr_whole = reg_wr && reg_addr == 8'h2a;
    wire logic wr_low = reg_wr && reg_addr == 8'h29;
    wire logic wr_ref = reg_wr && reg_addr == 8'h27;
    wire logic src_pll = sysclk.source == aps_pkg::APS_SRC_PLL;
    chk_restart_follows: assert property (wr_whole |=> pll_restart) else $error("no restart pulse");
    chk_restart_cause: assert property (pll_restart |-> $past(wr_whole)) else $error("stray restart");
    chk_postdiv_eight: assert property ($past(rst_n) && $past(rst_n, 2) |-> pll_ctrl.postdivide == 4'h8)
        else $error("postdivide wrong");
    chk_frac_low: assert property (wr_low |-> ##2 pll_ctrl.feedback_div[7:0] == $past(reg_wdata, 2))
        else $error("fraction low wrong");
    chk_whole_field: assert property (wr_whole |-> ##2 pll_ctrl.feedback_div[19:13] == $past(reg_wdata[6:0], 2))
        else $error("whole part wrong");
    chk_predivide_ratio: assert property (wr_ref && reg_wdata[4:2] <= 3'h4 |->
        ##2 pll_ctrl.predivide == 5'h01 << $past(reg_wdata[4:2], 2)) else $error("predivide wrong");
    chk_bypass_pll_off: assert property (wr_ref && reg_wdata[7:6] == 2'h0 |-> ##2 !pll_ctrl.pll_enable)
        else $error("pll on in bypass");
    chk_rate_family: assert property (reg_wr && reg_addr == 8'h17 |->
        ##2 sysclk.family_44k1 == ($past(reg_wdata[3:0], 2) inside {4'h2, 4'h6, 4'ha, 4'he}))
        else $error("family wrong");
    chk_refosc_no_digital: assert property (sysclk.digital_ok == !(sysclk.source == aps_pkg::APS_SRC_REFOSC))
        else $error("digital flag wrong");
    chk_pll_needs_lock: assert property (src_pll && !$past(src_pll) |-> $past(pll_lock_pin, 2))
        else $error("switched to unlocked pll");
    cov_restart: cover property (pll_restart);
    cov_pll_source: cover property (src_pll);
    cov_family: cover property (sysclk.family_44k1);
endmodule
`default_nettype wire

// File: aps_sysclk_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
module aps_sysclk_select_tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic run = 1'b0;
    wire logic ext_mclk_pin;
    wire logic pll_lock_pin;
    aps_pkg::aps_pll_ctrl_type pll_ctrl;
    logic pll_restart;
    aps_pkg::aps_sysclk_type sysclk;
    logic [7:0] d;
    int mismatches = 0;
    int total_checks = 0;
    logic [15:0] rst_tab [5] = '{16'h2700, 16'h2800, 16'h2900, 16'h2a20, 16'h170b};
    logic [15:0] msk_tab [6] = '{16'h27ff, 16'h281f, 16'h29ff, 16'h2a7f, 16'h170f, 16'h3000};
    logic [3:0] rates [11] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hb, 4'he, 4'hf};
    aps_sysclk_select DUT (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_mclk_pin(ext_mclk_pin),
        .pll_lock_pin(pll_lock_pin), .pll_ctrl(pll_ctrl), .pll_restart(pll_restart), .sysclk(sysclk));
    aps_mclk_model #(.HALF_NS(40), .LOCK_CYC(20)) u_src (.mclk(mclk), .run(run),
        .pll_enable(pll_ctrl.pll_enable), .restart(pll_restart), .pin(ext_mclk_pin), .lock(pll_lock_pin));
    initial begin
        forever #5 mclk = ~mclk;
    end
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Each access idles one edge first, so a strobe is never lowered and raised in one time step.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        tick(1);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        tick(1);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        v = reg_rdata;
    endtask
    task automatic wait_src(input aps_pkg::aps_src_type s);
        int i;
        for (i = 0; i < 300 && sysclk.source !== s; i++) tick(1);
        chk(sysclk.source, s);
        if (sysclk.source !== s) conclude();
    endtask
    initial begin
        tick(8);
        rst_n = 1'b1;
        for (int k = 0; k < 5; k++) begin
            rd(rst_tab[k][15:8], d);
            chk(d, rst_tab[k][7:0]);
        end
        for (int k = 0; k < 6; k++) begin
            wr(msk_tab[k][15:8], 8'hff);
            rd(msk_tab[k][15:8], d);
            chk(d, msk_tab[k][7:0]);
        end
        chk(sysclk.source, aps_pkg::APS_SRC_REFOSC);
        for (int k = 0; k < 5; k++) begin
            wr(8'h27, 8'(k << 2));
            tick(1);
            chk(pll_ctrl.predivide, 32'd1 << k);
        end
        wr(8'h2a, 8'h1e);
        chk(pll_restart, 1'b1);
        wr(8'h28, 8'h07);
        chk(pll_restart, 1'b0);
        wr(8'h29, 8'hea);
        tick(1);
        chk(pll_ctrl.feedback_div, {7'h1e, 5'h07, 8'hea});
        chk(pll_ctrl.postdivide, 4'h8);
        foreach (rates[k]) begin
            wr(8'h17, {4'h0, rates[k]});
            tick(1);
            chk(sysclk.family_44k1, rates[k] inside {4'h2, 4'h6, 4'ha, 4'he});
        end
        run = 1'b1;
        wait_src(aps_pkg::APS_SRC_MCLK);
        rd(8'h2b, d);
        chk(d[3:0], 4'h5);
        wr(8'h27, 8'h48);
        tick(1);
        chk({pll_ctrl.pll_enable, sysclk.source}, {1'b1, aps_pkg::APS_SRC_MCLK});
        wait_src(aps_pkg::APS_SRC_PLL);
        rd(8'h2b, d);
        chk(d[3:0], 4'hb);
        wr(8'h27, 8'h88);
        tick(1);
        chk(pll_ctrl.srm_enable, 1'b1);
        wr(8'h2a, 8'h1e);
        tick(1);
        chk(sysclk.source, aps_pkg::APS_SRC_MCLK);
        wait_src(aps_pkg::APS_SRC_PLL);
        run = 1'b0;
        wait_src(aps_pkg::APS_SRC_REFOSC);
        chk({sysclk.refosc_enable, sysclk.digital_ok}, 2'h2);
        wr(8'h27, 8'h00);
        run = 1'b1;
        wait_src(aps_pkg::APS_SRC_MCLK);
        chk(pll_ctrl.pll_enable, 1'b0);
        conclude();
    end
endmodule
bind aps_sysclk_select aps_sysclk_select_properties u_props (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_mclk_pin(ext_mclk_pin),
    .pll_lock_pin(pll_lock_pin), .pll_ctrl(pll_ctrl), .pll_restart(pll_restart), .sysclk(sysclk));
`default_nettype wire
